// *** bench/testbench.sv ***
// self-checking testbench for the power-mode sequencer
`timescale 1ns/1ps
module testbench;
  import lpm_pkg::*;
  logic              mclk = 1'b0;
  logic              rst = 1'b1;
  logic [3:0]        avs_address = 4'h0;
  logic              avs_read = 1'b0;
  logic              avs_write = 1'b0;
  logic [31:0]       avs_writedata = 32'h0;
  logic [31:0]       avs_readdata;
  logic              avs_waitrequest;
  logic              irq_req = 1'b0;
  logic              irq_enabled = 1'b0;
  logic              stack_full = 1'b0;
  logic              wdt_overflow = 1'b0;
  logic [PORT_W-1:0] port_a_pins = 8'hff;
  clk_ctl_type       clk_ctl;
  logic              wdt_clear, pc_sp_reset, irq_take, resume;
  logic              wait_n;
  logic [31:0]       rd_n;
  int                error_cnt = 0, cmp_count = 0, cyc = 0;
  int                n_wclr = 0, n_pcsp = 0, n_take = 0, n_res = 0;

  always #25 mclk = ~mclk;

  low_power_mode_controller DUT (.mclk(mclk), .rst(rst),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .irq_req(irq_req), .irq_enabled(irq_enabled),
    .stack_full(stack_full), .wdt_overflow(wdt_overflow),
    .port_a_pins(port_a_pins), .clk_ctl(clk_ctl),
    .wdt_clear(wdt_clear), .pc_sp_reset(pc_sp_reset),
    .irq_take(irq_take), .resume(resume));

  // inputs only move at rising edges, so mid-cycle copies are edge values
  always @(negedge mclk) begin
    wait_n <= avs_waitrequest;
    rd_n <= avs_readdata;
  end

  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (wdt_clear === 1'b1) n_wclr <= n_wclr + 1;
    if (pc_sp_reset === 1'b1) n_pcsp <= n_pcsp + 1;
    if (irq_take === 1'b1) n_take <= n_take + 1;
    if (resume === 1'b1) n_res <= n_res + 1;
    if (cyc == 30000) begin
      error_cnt++;
      end_sim();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic end_sim();
    $display("errors=%0d compares=%0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim

  task automatic cycles(input int n);
    repeat (n) @(posedge mclk);
  endtask : cycles

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= 1'b1;
    do @(posedge mclk); while (wait_n !== 1'b0);
    avs_write <= 1'b0;
    @(posedge mclk);
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    avs_address <= a;
    avs_read <= 1'b1;
    do @(posedge mclk); while (wait_n !== 1'b0);
    d = rd_n;
    avs_read <= 1'b0;
    @(posedge mclk);
  endtask : rd

  task automatic wait_mode(input mode_type m);
    logic [31:0] s;
    int n;
    n = 0;
    do begin rd(ADDR_STATUS, s); n++; end
      while (s[ST_MODE +: 3] !== m && n < 300);
    check(32'(s[ST_MODE +: 3]), 32'(m));
  endtask : wait_mode

  task automatic wait_res(input int r0);
    int n;
    n = 0;
    while (n_res == r0 && n < 3000) begin @(posedge mclk); n++; end
    check(32'(n_res - r0), 32'h1);
  endtask : wait_res

  // sys, wdt, time-base, sub clock enables and cpu run
  task automatic gates(input logic [4:0] exp);
    check(32'({clk_ctl.sys_clk_en, clk_ctl.wdt_clk_en, clk_ctl.tb_clk_en,
               clk_ctl.sub_clk_en, clk_ctl.cpu_run}), 32'(exp));
  endtask : gates

  task automatic halt_into(input logic [31:0] ctrl, input mode_type m);
    logic [31:0] s;
    int w0;
    wr(ADDR_CTRL, ctrl);
    w0 = n_wclr;
    wr(ADDR_CMD, 32'h1);
    wait_mode(m);
    check(32'(n_wclr - w0), 32'h1);
    rd(ADDR_STATUS, s);
    check(32'(s[1:0]), 32'h1);
  endtask : halt_into

  task automatic t_reset();
    logic [31:0] d;
    rd(ADDR_CTRL, d);
    check(d, CTRL_RESET);
    rd(ADDR_STATUS, d);
    check(32'(d[1:0]), 32'h0);
    gates(5'h1f);
    wr(ADDR_STATUS, 32'hff);
    rd(ADDR_STATUS, d);
    check(32'(d[1:0]), 32'h0);
    wr(4'h7, 32'hffff_ffff);
    rd(4'h7, d);
    check(d, 32'h0);
    wr(ADDR_WAKE, 32'ha5);
    rd(ADDR_WAKE, d);
    check(32'(d[7:0]), 32'ha5);
  endtask : t_reset

  task automatic t_slow();
    for (int i = 1; i < 8; i++) begin
      wr(ADDR_CTRL, 32'h090);
      wait_mode(RUN_SLOW);
      wr(ADDR_CTRL, (i == 1) ? 32'h081 : 32'h080 | (i << 4));
      wait_mode(RUN_NORMAL);
    end
  endtask : t_slow

  task automatic t_deep();
    logic [31:0] s;
    int c0, r0;
    wr(ADDR_WAKE, 32'h01);
    halt_into(32'h001, DEEP_SLEEP);
    gates(5'h00);
    rd(ADDR_STATUS, s);
    check(32'(s[ST_HTO]), 32'h0);
    port_a_pins <= 8'hfd;
    cycles(20);
    rd(ADDR_STATUS, s);
    check(32'(s[ST_MODE +: 3]), 32'(DEEP_SLEEP));
    r0 = n_res;
    c0 = cyc;
    port_a_pins <= 8'hfc;
    wait_res(r0);
    check(32'(cyc - c0 >= int'(HIGH_SPEED_RC_OSC_SETTLE)), 32'h1);
    rd(ADDR_STATUS, s);
    check(32'(s[ST_HTO]), 32'h1);
    gates(5'h15);
    port_a_pins <= 8'hff;
  endtask : t_deep

  task automatic t_subsleep();
    logic [31:0] s;
    int p0, r0;
    halt_into(32'h081, SUB_SLEEP);
    gates(5'h0a);
    p0 = n_pcsp;
    r0 = n_res;
    wdt_overflow <= 1'b1;
    @(posedge mclk);
    wdt_overflow <= 1'b0;
    wait_res(r0);
    check(32'(n_pcsp - p0), 32'h1);
    rd(ADDR_STATUS, s);
    check(32'(s[1:0]), 32'h3);
    wait_mode(RUN_NORMAL);
  endtask : t_subsleep

  task automatic t_subidle();
    int t0, r0;
    halt_into(32'h083, SUB_IDLE);
    gates(5'h0e);
    t0 = n_take;
    r0 = n_res;
    irq_enabled <= 1'b1;
    irq_req <= 1'b1;
    wait_res(r0);
    check(32'(n_take - t0), 32'h1);
    irq_req <= 1'b0;
    wait_mode(RUN_NORMAL);
  endtask : t_subidle

  task automatic t_fullidle();
    logic [31:0] s;
    int t0, r0;
    stack_full <= 1'b1;
    irq_req <= 1'b1;
    halt_into(32'h087, FULL_IDLE);
    gates(5'h1e);
    r0 = n_res;
    cycles(20);
    rd(ADDR_STATUS, s);
    check(32'(s[ST_MODE +: 3]), 32'(FULL_IDLE));
    check(32'(n_res - r0), 32'h0);
    irq_req <= 1'b0;
    cycles(4);
    t0 = n_take;
    irq_req <= 1'b1;
    wait_res(r0);
    check(32'(n_take - t0), 32'h0);
    rd(ADDR_STATUS, s);
    check(32'(s[ST_PEND]), 32'h1);
    stack_full <= 1'b0;
    cycles(2);
    rd(ADDR_STATUS, s);
    check(32'(s[ST_PEND]), 32'h0);
    irq_req <= 1'b0;
    irq_enabled <= 1'b0;
    wait_mode(RUN_NORMAL);
    wr(ADDR_CMD, 32'h2);
    rd(ADDR_STATUS, s);
    check(32'(s[ST_PDF]), 32'h0);
  endtask : t_fullidle

  task automatic t_fast();
    logic [31:0] s;
    int c0, r0;
    halt_into(32'h289, SUB_SLEEP);
    check(32'(clk_ctl.hs_osc_en), 32'h0);
    r0 = n_res;
    c0 = cyc;
    port_a_pins <= 8'hfe;
    cycles(8);
    gates(5'h1f);
    rd(ADDR_STATUS, s);
    check(32'(s[ST_SUBSYS]), 32'h1);
    check(32'(s[ST_HTO]), 32'h0);
    wait_res(r0);
    check(32'(cyc - c0 >= int'(HXT_SETTLE)), 32'h1);
    rd(ADDR_STATUS, s);
    check(32'({s[ST_SUBSYS], s[ST_HTO]}), 32'h1);
    port_a_pins <= 8'hff;
  endtask : t_fast

  initial begin
    cycles(3);
    rst <= 1'b0;
    @(posedge mclk);
    t_reset();
    t_slow();
    t_deep();
    t_subsleep();
    t_subidle();
    t_fullidle();
    t_fast();
    end_sim();
  end
endmodule : testbench

// *** logic/low_power_mode_controller.sv ***
// power-mode sequencer: halt state choice, clock gating, wake-up, settle
//
// The placing of the registers and the Avalon-MM register port were left to the implementer.
`timescale 1ns/1ps
module low_power_mode_controller
  import lpm_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              rst,
  // avalon-mm slave
  input  wire logic [3:0]        avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  output logic      [31:0]       avs_readdata,
  output logic                   avs_waitrequest,
  // cpu side events
  input  wire logic              irq_req,
  input  wire logic              irq_enabled,
  input  wire logic              stack_full,
  input  wire logic              wdt_overflow,
  input  wire logic [PORT_W-1:0] port_a_pins,
  // outputs
  output clk_ctl_type            clk_ctl,
  output logic                   wdt_clear,
  output logic                   pc_sp_reset,
  output logic                   irq_take,
  output logic                   resume
);
  typedef struct packed {
    mode_type          mode;
    mode_type          wake_target;
    logic [9:0]        ctrl;
    logic              power_down_flag;
    logic              to;
    logic [PORT_W-1:0] port_a_wake_enable;
    logic [PORT_W-1:0] pa_s1;
    logic [PORT_W-1:0] pa_s2;
    logic [PORT_W-1:0] pa_prev;
    logic              irq_blocked;
    logic              irq_pending;
    logic              start_hs;
    logic              start_ls;
    logic              ack;
    logic [31:0]       rdata;
    clk_ctl_type       clk;
    logic              wdt_clr;
    logic              pcsp;
    logic              take;
    logic              res;
  } ctl_state_type;

  ctl_state_type s_q, s_d;
  logic hs_ready;
  logic ls_ready;
  logic [9:0] hs_len;
  logic halted;
  logic [PORT_W-1:0] pa_fall;
  logic irq_wake;
  logic wake;
  logic halt_cmd;
  logic clr_cmd;
  logic hto_flag;

  assign hs_len = s_q.ctrl[CTRL_HXT] ? HXT_SETTLE : HIGH_SPEED_RC_OSC_SETTLE;

  settle_counter u_settle (
    .mclk     (mclk),
    .rst      (rst),
    .start_hs (s_q.start_hs),
    .start_ls (s_q.start_ls),
    .hs_len   (hs_len),
    .hs_ready (hs_ready),
    .ls_ready (ls_ready)
  );

  always_comb begin
    halted   = (s_q.mode == DEEP_SLEEP) || (s_q.mode == SUB_SLEEP) ||
               (s_q.mode == SUB_IDLE) || (s_q.mode == FULL_IDLE);
    pa_fall  = s_q.pa_prev & ~s_q.pa_s2 & s_q.port_a_wake_enable;
    irq_wake = irq_req && !s_q.irq_blocked;
    // ready flag reads low while the high-speed oscillator is stopped
    hto_flag = hs_ready && s_q.clk.hs_osc_en && !s_q.start_hs;
    wake     = halted && ((|pa_fall) || irq_wake || wdt_overflow);
    halt_cmd = avs_write && !s_q.ack && (avs_address == ADDR_CMD) &&
               avs_writedata[CMD_HALT];
    clr_cmd  = avs_write && !s_q.ack && (avs_address == ADDR_CMD) &&
               avs_writedata[CMD_CLRWDT];
  end

  always_comb begin
    s_d = s_q;
    s_d.pa_s1   = port_a_pins;
    s_d.pa_s2   = s_q.pa_s1;
    s_d.pa_prev = s_q.pa_s2;
    s_d.start_hs = 1'b0;
    s_d.start_ls = 1'b0;
    s_d.wdt_clr = 1'b0;
    s_d.pcsp    = 1'b0;
    s_d.take    = 1'b0;
    s_d.res     = 1'b0;
    s_d.ack     = (avs_read || avs_write) && !s_q.ack;
    s_d.rdata   = 32'h0000_0000;
    // bus access; registers stay readable and writable while halted
    if (avs_read && !s_q.ack) begin
      unique case (avs_address)
        ADDR_CTRL:   s_d.rdata = {22'h000000, s_q.ctrl};
        ADDR_STATUS: s_d.rdata = {22'h000000, s_q.clk.periph_on_sub,
                                  s_q.irq_pending, 1'b0, s_q.mode,
                                  1'b0, hto_flag, s_q.to, s_q.power_down_flag};
        ADDR_WAKE:   s_d.rdata = {24'h000000, s_q.port_a_wake_enable};
        default:     s_d.rdata = 32'h0000_0000;
      endcase
    end
    if (avs_write && !s_q.ack) begin
      if (avs_address == ADDR_CTRL) begin
        s_d.ctrl = avs_writedata[9:0];
      end
      if (avs_address == ADDR_WAKE) begin
        s_d.port_a_wake_enable = avs_writedata[PORT_W-1:0];
      end
    end
    if (clr_cmd) begin
      s_d.power_down_flag     = 1'b0;
      s_d.wdt_clr = 1'b1;
    end
    if (irq_req && irq_enabled && !stack_full) begin
      s_d.irq_pending = 1'b0;
    end
    if (!irq_req) begin
      s_d.irq_blocked = 1'b0;
    end
    unique case (s_q.mode)
      RUN_NORMAL, RUN_SLOW: begin
        if (!s_q.ctrl[CTRL_HSEL] &&
            s_q.ctrl[CTRL_CKS_LO +: 3] < CKS_FAST_MIN) begin
          s_d.mode = RUN_SLOW;
        end else if (s_q.mode == RUN_SLOW) begin
          s_d.mode = WAKE_SETTLE;
          s_d.wake_target = RUN_NORMAL;
          s_d.start_hs = 1'b1;
        end
        if (halt_cmd) begin
          s_d.power_down_flag = 1'b1;
          s_d.to  = 1'b0;
          s_d.wdt_clr = 1'b1;
          s_d.irq_blocked = irq_req;
          if (!s_q.ctrl[CTRL_IDLE]) begin
            if (!s_q.ctrl[CTRL_WDT_EN] && !s_q.ctrl[CTRL_LVD_EN]) begin
              s_d.mode = DEEP_SLEEP;
            end else begin
              s_d.mode = SUB_SLEEP;
            end
          end else if (!s_q.ctrl[CTRL_KEEP]) begin
            s_d.mode = SUB_IDLE;
          end else begin
            s_d.mode = FULL_IDLE;
          end
        end
      end
      DEEP_SLEEP, SUB_SLEEP, SUB_IDLE, FULL_IDLE: begin
        if (wake) begin
          if (wdt_overflow) begin
            s_d.to   = 1'b1;
            s_d.pcsp = 1'b1;
          end
          if (irq_wake && !(irq_enabled && !stack_full)) begin
            s_d.irq_pending = 1'b1;
          end
          s_d.wake_target = RUN_NORMAL;
          if (s_q.mode == FULL_IDLE) begin
            s_d.mode = RUN_NORMAL;
            s_d.res  = 1'b1;
            s_d.take = irq_wake && irq_enabled && !stack_full;
          end else begin
            s_d.mode = WAKE_SETTLE;
            s_d.start_hs = 1'b1;
            // low-speed oscillator was off too; it waits for high-speed
            s_d.start_ls = (s_q.mode == DEEP_SLEEP);
            s_d.take = irq_wake && irq_enabled && !stack_full;
          end
        end
      end
      WAKE_SETTLE: begin
        if (hs_ready && !s_q.start_hs) begin
          s_d.mode = s_q.wake_target;
          s_d.res  = 1'b1;
        end
      end
      default: s_d.mode = RUN_NORMAL;
    endcase
    // clock gating per mode
    s_d.clk.sub_clk_en = s_q.ctrl[CTRL_WDT_EN] || s_q.ctrl[CTRL_LVD_EN];
    s_d.clk.wdt_clk_en = s_q.ctrl[CTRL_WDT_EN];
    s_d.clk.tb_clk_en  = 1'b1;
    s_d.clk.sys_clk_en = 1'b1;
    s_d.clk.hs_osc_en  = (s_d.mode != RUN_SLOW);
    s_d.clk.cpu_run    = (s_d.mode == RUN_NORMAL) || (s_d.mode == RUN_SLOW);
    s_d.clk.periph_on_sub = (s_d.mode == RUN_SLOW);
    unique case (s_d.mode)
      DEEP_SLEEP: begin
        s_d.clk.sys_clk_en = 1'b0;
        s_d.clk.wdt_clk_en = 1'b0;
        s_d.clk.tb_clk_en  = 1'b0;
        s_d.clk.sub_clk_en = 1'b0;
        s_d.clk.hs_osc_en  = 1'b0;
      end
      SUB_SLEEP: begin
        s_d.clk.sys_clk_en = 1'b0;
        s_d.clk.tb_clk_en  = 1'b0;
        s_d.clk.hs_osc_en  = 1'b0;
      end
      SUB_IDLE: begin
        s_d.clk.sys_clk_en = 1'b0;
        s_d.clk.sub_clk_en = 1'b1;
        s_d.clk.hs_osc_en  = 1'b0;
      end
      WAKE_SETTLE: begin
        // with hxt selected and sub clock already on, fast wake runs system from low-speed rc until ready
        s_d.clk.sys_clk_en = s_q.ctrl[CTRL_HXT] && s_q.ctrl[CTRL_FAST] &&
                             s_q.clk.sub_clk_en;
        s_d.clk.periph_on_sub = s_d.clk.sys_clk_en;
        s_d.clk.cpu_run = s_d.clk.sys_clk_en;
      end
      default: begin
        s_d.clk.sys_clk_en = 1'b1;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s_q <= '0;
      s_q.ctrl <= CTRL_RESET[9:0];
      s_q.clk  <= 7'h7f;
    end else begin
      s_q <= s_d;
    end
  end

  assign avs_readdata    = s_q.rdata;
  assign avs_waitrequest = (avs_read || avs_write) && !s_q.ack;
  assign clk_ctl     = s_q.clk;
  assign wdt_clear   = s_q.wdt_clr;
  assign pc_sp_reset = s_q.pcsp;
  assign irq_take    = s_q.take;
  assign resume      = s_q.res;

  property p_halt_flags;
    @(posedge mclk) disable iff (rst)
      halt_cmd && !halted && s_q.mode != WAKE_SETTLE |=> s_q.power_down_flag && !s_q.to;
  endproperty
  a_halt_flags: assert property (p_halt_flags) else $error("halt flags");

  property p_deep;
    @(posedge mclk) disable iff (rst)
      halt_cmd && s_q.mode == RUN_NORMAL && !s_q.ctrl[CTRL_IDLE] &&
      !s_q.ctrl[CTRL_WDT_EN] && !s_q.ctrl[CTRL_LVD_EN]
      |=> s_q.mode == DEEP_SLEEP ##1 !clk_ctl.sys_clk_en && !clk_ctl.wdt_clk_en;
  endproperty
  a_deep: assert property (p_deep) else $error("deep sleep entry");

  property p_full_idle;
    @(posedge mclk) disable iff (rst)
      s_q.mode == FULL_IDLE |->
        clk_ctl.sys_clk_en && clk_ctl.tb_clk_en && !clk_ctl.cpu_run;
  endproperty
  a_full_idle: assert property (p_full_idle) else $error("full idle clk");

  property p_clr;
    @(posedge mclk) disable iff (rst)
      clr_cmd && !halt_cmd |=> !s_q.power_down_flag;
  endproperty
  a_clr: assert property (p_clr) else $error("clear wdt pdf");

  property p_wdt_wake;
    @(posedge mclk) disable iff (rst)
      halted && wdt_overflow |=> s_q.to && pc_sp_reset && !halted;
  endproperty
  a_wdt_wake: assert property (p_wdt_wake) else $error("wdt wake");

  property p_settle;
    @(posedge mclk) disable iff (rst)
      s_q.mode == WAKE_SETTLE && !hs_ready |=> s_q.mode == WAKE_SETTLE;
  endproperty
  a_settle: assert property (p_settle) else $error("early fetch");

  property p_hold;
    @(posedge mclk) disable iff (rst)
      halted && !wake |=> $stable(s_q.mode) && !resume;
  endproperty
  a_hold: assert property (p_hold) else $error("halt not held");

  property p_sub_idle;
    @(posedge mclk) disable iff (rst)
      s_q.mode == SUB_IDLE |->
        !clk_ctl.sys_clk_en && clk_ctl.tb_clk_en && clk_ctl.sub_clk_en;
  endproperty
  a_sub_idle: assert property (p_sub_idle) else $error("sub idle clk");

  property p_deep_clk;
    @(posedge mclk) disable iff (rst)
      s_q.mode == DEEP_SLEEP |-> !clk_ctl.sys_clk_en && !clk_ctl.wdt_clk_en &&
        !clk_ctl.tb_clk_en && !clk_ctl.sub_clk_en && !clk_ctl.hs_osc_en;
  endproperty
  a_deep_clk: assert property (p_deep_clk) else $error("deep clocks");

  property p_sub_sleep;
    @(posedge mclk) disable iff (rst)
      s_q.mode == SUB_SLEEP |-> !clk_ctl.sys_clk_en && !clk_ctl.tb_clk_en &&
        !clk_ctl.hs_osc_en;
  endproperty
  a_sub_sleep: assert property (p_sub_sleep) else $error("sub sleep");

  property p_run_wdt;
    @(posedge mclk) disable iff (rst)
      s_q.mode == RUN_NORMAL && $stable(s_q.ctrl) |->
        clk_ctl.wdt_clk_en == s_q.ctrl[CTRL_WDT_EN];
  endproperty
  a_run_wdt: assert property (p_run_wdt) else $error("wdt clock");

  property p_pin_wake;
    @(posedge mclk) disable iff (rst)
      halted && (|pa_fall) |=> !halted;
  endproperty
  a_pin_wake: assert property (p_pin_wake) else $error("pin wake");

  property p_take;
    @(posedge mclk) disable iff (rst)
      halted && irq_wake && irq_enabled && !stack_full |=> irq_take;
  endproperty
  a_take: assert property (p_take) else $error("irq take");
endmodule : low_power_mode_controller

// *** logic/lpm_pkg.sv ***
// package: register map, field positions, timing and types of the mode controller
package lpm_pkg;
  localparam logic [3:0] ADDR_CTRL   = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h1;
  localparam logic [3:0] ADDR_WAKE   = 4'h2;
  localparam logic [3:0] ADDR_CMD    = 4'h3;
  // control register fields
  localparam int CTRL_HSEL    = 0;
  localparam int CTRL_IDLE    = 1;
  localparam int CTRL_KEEP    = 2;
  localparam int CTRL_FAST    = 3;
  localparam int CTRL_CKS_LO  = 4;
  localparam int CTRL_WDT_EN  = 7;
  localparam int CTRL_LVD_EN  = 8;
  localparam int CTRL_HXT     = 9;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0080;
  // status register fields
  localparam int ST_PDF   = 0;
  localparam int ST_TO    = 1;
  localparam int ST_HTO   = 2;
  localparam int ST_MODE  = 4;
  localparam int ST_PEND  = 8;
  localparam int ST_SUBSYS = 9;
  // command register bits (write one)
  localparam int CMD_HALT   = 0;
  localparam int CMD_CLRWDT = 1;
  // settle counts in mclk cycles
  localparam logic [9:0] HXT_SETTLE  = 10'h200;
  localparam logic [9:0] HIGH_SPEED_RC_OSC_SETTLE = 10'h010;
  localparam logic [9:0] LXT_SETTLE  = 10'h200;
  localparam logic [2:0] CKS_FAST_MIN = 3'h2;
  localparam int PORT_W = 8;

  typedef enum logic [2:0] {
    RUN_NORMAL  = 3'b000,
    RUN_SLOW    = 3'b001,
    DEEP_SLEEP  = 3'b010,
    SUB_SLEEP   = 3'b011,
    SUB_IDLE    = 3'b100,
    FULL_IDLE   = 3'b101,
    WAKE_SETTLE = 3'b110
  } mode_type;

  typedef struct packed {
    logic sys_clk_en;
    logic wdt_clk_en;
    logic tb_clk_en;
    logic sub_clk_en;
    logic hs_osc_en;
    logic cpu_run;
    logic periph_on_sub;
  } clk_ctl_type;

  typedef struct packed {
    logic [31:0] addr;
    logic        read;
    logic        write;
    logic [31:0] wdata;
  } bus_req_type;
endpackage : lpm_pkg

// *** logic/settle_counter.sv ***
// shared oscillator settle counter, high-speed first then low-speed
`timescale 1ns/1ps
module settle_counter
  import lpm_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       start_hs,
  input  wire logic       start_ls,
  input  wire logic [9:0] hs_len,
  output logic            hs_ready,
  output logic            ls_ready
);
  typedef struct packed {
    logic [9:0] cnt;
    logic       hs_busy;
    logic       ls_wait;
    logic       ls_busy;
    logic       hs_rdy;
    logic       ls_rdy;
  } settle_state_type;

  settle_state_type s_q, s_d;

  always_comb begin
    s_d = s_q;
    if (start_hs) begin
      s_d.hs_busy = 1'b1;
      s_d.hs_rdy  = 1'b0;
      s_d.cnt     = 10'h000;
    end
    if (start_ls) begin
      s_d.ls_wait = 1'b1;
      s_d.ls_rdy  = 1'b0;
    end
    if (s_q.hs_busy && !start_hs) begin
      s_d.cnt = s_q.cnt + 10'h001;
      if (s_q.cnt + 10'h001 >= hs_len) begin
        s_d.hs_busy = 1'b0;
        s_d.hs_rdy  = 1'b1;
        s_d.cnt     = 10'h000;
      end
    end else if (s_q.ls_wait && !s_q.hs_busy && !start_hs) begin
      // low-speed only counts once high-speed finished
      s_d.ls_wait = 1'b0;
      s_d.ls_busy = 1'b1;
      s_d.cnt     = 10'h000;
    end else if (s_q.ls_busy && !start_hs) begin
      s_d.cnt = s_q.cnt + 10'h001;
      if (s_q.cnt + 10'h001 >= LXT_SETTLE) begin
        s_d.ls_busy = 1'b0;
        s_d.ls_rdy  = 1'b1;
        s_d.cnt     = 10'h000;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign hs_ready = s_q.hs_rdy;
  assign ls_ready = s_q.ls_rdy;
endmodule : settle_counter
